// [src/hbfp_pkg.sv]
package hbfp_pkg;

    // ----------------------------------------------------------------
    // Word layout
    // ----------------------------------------------------------------
    localparam int          WORD_BITS        = 16;
    localparam int          CHANNELS         = 12;
    localparam int          COUNT_BITS       = 5;
    localparam int          TIMER_WIDTH      = 16;

    localparam int          IN_STANDBY_BIT   = 15;
    localparam int          IN_SHORT_SEL_BIT = 14;
    localparam int          IN_OPEN_LOAD_BIT = 13;
    localparam int          IN_CMD_LSB       = 1;
    localparam int          IN_CLEAR_BIT     = 0;

    localparam int          OUT_SUPPLY_BIT   = 15;
    localparam int          OUT_INHIBIT_BIT  = 14;
    localparam int          OUT_SHORT_BIT    = 13;
    localparam int          OUT_STATUS_LSB   = 1;
    localparam int          OUT_PREWARN_BIT  = 0;

    localparam logic [15:0] INPUT_RESET      = 16'hE000;
    localparam logic [15:0] OUT_ALL_HIGH     = 16'hFFFF;
    localparam logic [4:0]  FRAME_LAST       = 5'h0F;
    localparam logic [4:0]  FRAME_DONE       = 5'h10;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLOCK_FREQ_MHZ   = 50;
    localparam int          SHORT_FAST_US    = 50;
    localparam int          SHORT_SLOW_US    = 100;
    localparam int          SHORT_FAST_CYCLES = SHORT_FAST_US * CLOCK_FREQ_MHZ;
    localparam int          SHORT_SLOW_CYCLES = SHORT_SLOW_US * CLOCK_FREQ_MHZ;

endpackage

// [src/hbfp_short_timer.sv]
`timescale 1ns/10ps
module hbfp_short_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             over_current,
    input  wire logic [WIDTH-1:0] delay_cycles,
    input  wire logic             clear,
    output logic                  tripped
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             next_tripped;

    // ----------------------------------------------------------------
    // Delay counter and sticky trip
    // ----------------------------------------------------------------
    always_comb begin
        next_count   = count;
        next_tripped = tripped;
        if (!over_current) begin
            next_count = '0; // RULE14
        end else if (count < delay_cycles) begin
            next_count = count + 1'b1; // RULE6
        end
        if (clear) begin
            next_tripped = 1'b0; // RULE9
        end
        // Set after clear so a trip in the clear cycle is kept
        if (over_current && count >= delay_cycles) begin
            next_tripped = 1'b1; // RULE7 RULE8
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            tripped <= 1'b0;
        end else begin
            count   <= next_count;
            tripped <= next_tripped;
        end
    end

endmodule

// [src/hbfp_core.sv]
// Functional notes
// RULE1 - The prewarning flag sets on the prewarn-set comparator and clears on the prewarn-reset comparator.
// RULE2 - When chip select falls the prewarning flag is driven on the serial output before any clock.
// RULE3 - A frame ended before sixteen bits leaves input and output words untouched.
// RULE4 - Overtemperature turns every output off and reads back an all-ones output word.
// RULE5 - After shutdown outputs return only once cool and a clear request has been written.
// RULE6 - An overcurrent on a channel limits it and starts that channel's delay counter at once.
// RULE7 - A short lasting the selected delay disables that channel and sets the short flag.
// RULE8 - The prewarning flag does not shorten the short delay.
// RULE9 - A clear request drops the short flag and re-enables the channels it disabled.
// RULE10 - A low standby bit or a low standby pin inhibits all outputs.
// RULE11 - The serial interface keeps working while inhibited.
// RULE12 - Outputs run only when the standby bit and the standby pin are both high.
// RULE13 - After reset the input word holds standby, delay select and open-load disable high, rest low.
// RULE14 - A channel whose overcurrent ends before the delay restarts its counter from zero.
`timescale 1ns/10ps
module hbfp_core
    import hbfp_pkg::*;
#(
    parameter int FAST_CYCLES = SHORT_FAST_CYCLES,
    parameter int SLOW_CYCLES = SHORT_SLOW_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                link_clock,
    input  wire logic                chip_select_n,
    input  wire logic                serial_in,
    output logic                     serial_out,
    output logic                     serial_out_oe,
    input  wire logic                standby_pin,
    input  wire logic                temp_prewarn_set,
    input  wire logic                temp_prewarn_reset,
    input  wire logic                temp_shutdown,
    input  wire logic                temp_switch_on,
    input  wire logic [CHANNELS-1:0] over_current,
    output logic      [CHANNELS-1:0] switch_on,
    output logic      [CHANNELS-1:0] current_limit,
    output logic                     open_load_disable,
    output logic                     thermal_prewarn_flag,
    output logic                     short_detect_flag,
    output logic                     thermal_shutdown,
    output logic                     inhibited
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int PIN_BITS = CHANNELS + 7;

    logic [PIN_BITS-1:0] pin_meta;
    logic [PIN_BITS-1:0] pin_sync;
    logic [PIN_BITS-1:0] pin_raw;
    logic                done_toggle;
    logic                cs_idle;
    logic                toggle_seen;
    logic                standby_ok;
    logic                warm;
    logic                cool;
    logic                hot;
    logic                safe;
    logic [CHANNELS-1:0] oc_sync;

    assign pin_raw = {over_current, done_toggle, chip_select_n, standby_pin,
                      temp_prewarn_set, temp_prewarn_reset, temp_shutdown,
                      temp_switch_on};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign oc_sync     = pin_sync[PIN_BITS-1:7];
    assign toggle_seen = pin_sync[6];
    assign cs_idle     = pin_sync[5];
    assign standby_ok  = pin_sync[4];
    assign warm        = pin_sync[3];
    assign cool        = pin_sync[2];
    assign hot         = pin_sync[1];
    assign safe        = pin_sync[0];

    // ----------------------------------------------------------------
    // Link side: shift register on the link clock
    // ----------------------------------------------------------------
    logic [COUNT_BITS-1:0] bit_count;
    logic [COUNT_BITS-1:0] next_bit_count;
    logic [WORD_BITS-2:0]  shift;
    logic [WORD_BITS-2:0]  next_shift;
    logic [WORD_BITS-1:0]  rx_word;
    logic [WORD_BITS-1:0]  next_rx_word;
    logic                  next_done_toggle;
    logic [WORD_BITS-1:0]  snapshot;

    // Keeps running under inhibit; only chip select frames it
    always_comb begin
        next_bit_count   = bit_count; // RULE11
        next_shift       = {shift[WORD_BITS-3:0], serial_in};
        next_rx_word     = rx_word;
        next_done_toggle = done_toggle;
        if (bit_count < FRAME_DONE) begin
            next_bit_count = bit_count + 1'b1;
        end
        // Word is only handed over on the sixteenth bit
        if (bit_count == FRAME_LAST) begin
            next_rx_word     = {shift, serial_in}; // RULE3
            next_done_toggle = ~done_toggle;
        end
    end

    // Link clock may stop between frames, so chip select clears the count
    always_ff @(posedge link_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_count <= '0;
            shift     <= '0;
        end else begin
            bit_count <= next_bit_count;
            shift     <= next_shift;
        end
    end

    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_word     <= '0;
            done_toggle <= 1'b0;
        end else begin
            rx_word     <= next_rx_word;
            done_toggle <= next_done_toggle;
        end
    end

    function automatic logic hbfp_frame_bit(
        input logic [WORD_BITS-1:0]  word,
        input logic [COUNT_BITS-1:0] count
    );
        if (count == '0) begin
            return word[OUT_PREWARN_BIT];
        end else if (count < FRAME_DONE) begin
            return word[WORD_BITS - int'(count)];
        end
        return 1'b0;
    endfunction

    // Must show the flag before any link edge, hence not registered
    assign serial_out    = hbfp_frame_bit(snapshot, bit_count); // RULE2
    assign serial_out_oe = ~chip_select_n;

    // ----------------------------------------------------------------
    // Frame hand-over into the core clock
    // ----------------------------------------------------------------
    logic                 toggle_last;
    logic                 cs_last;
    logic                 pending;
    logic                 next_pending;
    logic [WORD_BITS-1:0] in_reg;
    logic [WORD_BITS-1:0] next_in_reg;
    logic                 commit;
    logic                 clear_req;
    logic                 armed;

    // rx_word is quiet for many core cycles after the toggle lands
    always_comb begin
        // Toggle and select edge may land in one cycle; keep that frame
        armed        = pending || (toggle_seen != toggle_last);
        next_pending = armed;
        next_in_reg  = in_reg;
        commit       = 1'b0;
        if (cs_idle && !cs_last) begin
            commit       = armed; // RULE3
            next_pending = 1'b0;
            if (armed) begin
                next_in_reg = rx_word;
            end
        end
    end

    assign clear_req = commit && rx_word[IN_CLEAR_BIT];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            toggle_last <= 1'b0;
            cs_last     <= 1'b1;
            pending     <= 1'b0;
            in_reg      <= INPUT_RESET; // RULE13
        end else begin
            toggle_last <= toggle_seen;
            cs_last     <= cs_idle;
            pending     <= next_pending;
            in_reg      <= next_in_reg;
        end
    end

    // ----------------------------------------------------------------
    // Thermal flags
    // ----------------------------------------------------------------
    logic next_prewarn;
    logic next_shutdown;

    always_comb begin
        next_prewarn  = thermal_prewarn_flag;
        next_shutdown = thermal_shutdown;
        if (cool) begin
            next_prewarn = 1'b0; // RULE1
        end
        if (warm) begin
            next_prewarn = 1'b1; // RULE1
        end
        if (safe && clear_req) begin
            next_shutdown = 1'b0; // RULE5
        end
        if (hot) begin
            next_shutdown = 1'b1; // RULE4
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            thermal_prewarn_flag <= 1'b0;
            thermal_shutdown     <= 1'b0;
        end else begin
            thermal_prewarn_flag <= next_prewarn;
            thermal_shutdown     <= next_shutdown;
        end
    end

    // ----------------------------------------------------------------
    // Short-circuit timers
    // ----------------------------------------------------------------
    logic [TIMER_WIDTH-1:0] delay_cycles;
    logic [CHANNELS-1:0]    tripped;

    assign delay_cycles = in_reg[IN_SHORT_SEL_BIT]
                        ? TIMER_WIDTH'(SLOW_CYCLES)
                        : TIMER_WIDTH'(FAST_CYCLES); // RULE7

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_short
        hbfp_short_timer #(
            .WIDTH        (TIMER_WIDTH)
        ) u_timer (
            .clock        (clock),
            .rst_n        (rst_n),
            .over_current (oc_sync[ch]),
            .delay_cycles (delay_cycles),
            .clear        (clear_req),
            .tripped      (tripped[ch])
        );
    end

    // ----------------------------------------------------------------
    // Output stages and read-back word
    // ----------------------------------------------------------------
    logic                 next_inhibited;
    logic [CHANNELS-1:0]  next_switch_on;
    logic [WORD_BITS-1:0] next_snapshot;
    logic [WORD_BITS-1:0] status;

    always_comb begin
        next_inhibited = !in_reg[IN_STANDBY_BIT] || !standby_ok; // RULE10
        // Both sources must agree before any stage drives
        next_switch_on = in_reg[IN_CMD_LSB +: CHANNELS] & ~tripped; // RULE9
        if (next_inhibited || thermal_shutdown) begin
            next_switch_on = '0; // RULE4 RULE12
        end
        status                                = '0;
        status[OUT_PREWARN_BIT]               = thermal_prewarn_flag;
        status[OUT_STATUS_LSB +: CHANNELS]    = tripped;
        status[OUT_SHORT_BIT]                 = |tripped;
        status[OUT_INHIBIT_BIT]               = inhibited;
        status[OUT_SUPPLY_BIT]                = 1'b0;
        if (thermal_shutdown) begin
            status = OUT_ALL_HIGH; // RULE4
        end
        // Frozen during a frame so the link sees a stable word
        next_snapshot = cs_idle ? status : snapshot; // RULE3
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inhibited         <= 1'b1;
            switch_on         <= '0;
            current_limit     <= '0;
            short_detect_flag <= 1'b0;
            open_load_disable <= 1'b1;
            snapshot          <= '0;
        end else begin
            inhibited         <= next_inhibited;
            switch_on         <= next_switch_on;
            current_limit     <= oc_sync & switch_on; // RULE6
            short_detect_flag <= |tripped; // RULE7
            open_load_disable <= in_reg[IN_OPEN_LOAD_BIT];
            snapshot          <= next_snapshot;
        end
    end

endmodule

// [verif/hbfp_core_monitor.sv]
`timescale 1ns/10ps
module hbfp_core_monitor #(
    parameter int FAST_CYCLES = 8,
    parameter int SLOW_CYCLES = 16
) (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        chip_select_n,
    input wire logic        serial_out_oe,
    input wire logic        standby_pin,
    input wire logic        temp_prewarn_set,
    input wire logic        temp_prewarn_reset,
    input wire logic        temp_shutdown,
    input wire logic [11:0] over_current,
    input wire logic [11:0] switch_on,
    input wire logic [11:0] current_limit,
    input wire logic        thermal_prewarn_flag,
    input wire logic        short_detect_flag,
    input wire logic        thermal_shutdown,
    input wire logic        inhibited
);
    // ------------------------------------------------
    // Overcurrent run length
    // ------------------------------------------------
    // Counts any channel, so shorts are applied one channel at a time
    logic [15:0] oc_run;
    logic [15:0] next_oc_run;

    always_comb begin
        next_oc_run = (|over_current) ? oc_run + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            oc_run <= 16'h0000;
        end else begin
            oc_run <= next_oc_run;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_pw_set;
        temp_prewarn_set [*3];
    endsequence
    sequence s_pw_clr;
        (!temp_prewarn_set && temp_prewarn_reset) [*3];
    endsequence
    sequence s_hot;
        temp_shutdown [*3];
    endsequence
    sequence s_pin_low;
        !standby_pin [*3];
    endsequence

    a_oe_follows_cs: assert property (
        serial_out_oe == !chip_select_n)
        else $error("serial output enable does not follow select");
    a_prewarn_sets: assert property (
        s_pw_set |-> ##1 thermal_prewarn_flag)
        else $error("prewarning flag not set");
    a_prewarn_clears: assert property (
        s_pw_clr |-> ##1 !thermal_prewarn_flag)
        else $error("prewarning flag not cleared");
    a_shutdown_sets: assert property (
        s_hot |-> ##1 thermal_shutdown)
        else $error("overtemperature not latched");
    a_shutdown_off: assert property (
        thermal_shutdown |=> switch_on == 12'h000)
        else $error("stage on during shutdown");
    a_inhibit_off: assert property (
        inhibited |-> switch_on == 12'h000)
        else $error("stage on while inhibited");
    a_pin_inhibits: assert property (
        s_pin_low |-> ##1 inhibited)
        else $error("standby pin did not inhibit");
    a_limit_tracks: assert property (
        current_limit == ($past(over_current, 3) & $past(switch_on)))
        else $error("current limit does not track overcurrent");
    a_short_not_early: assert property (
        $rose(short_detect_flag) |-> oc_run > FAST_CYCLES)
        else $error("short flag before delay");
    a_short_not_late: assert property (
        oc_run == SLOW_CYCLES + 8 |-> short_detect_flag)
        else $error("short flag missing after delay");
endmodule

bind hbfp_core hbfp_core_monitor #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
) u_mon (
    .clock(clock), .resetn(resetn), .chip_select_n(chip_select_n),
    .serial_out_oe(serial_out_oe), .standby_pin(standby_pin),
    .temp_prewarn_set(temp_prewarn_set),
    .temp_prewarn_reset(temp_prewarn_reset),
    .temp_shutdown(temp_shutdown), .over_current(over_current),
    .switch_on(switch_on), .current_limit(current_limit),
    .thermal_prewarn_flag(thermal_prewarn_flag),
    .short_detect_flag(short_detect_flag),
    .thermal_shutdown(thermal_shutdown), .inhibited(inhibited)
);

// [verif/hbfp_host_model.sv]
`timescale 1ns/10ps
module hbfp_host_model (
    output logic      link_clock,
    output logic      chip_select_n,
    output logic      serial_in,
    input wire logic  serial_out,
    input wire logic  serial_out_oe
);
    initial begin
        link_clock = 1'h0;
        chip_select_n = 1'h1;
        serial_in = 1'h0;
    end

    // Link clock runs only inside a frame, 12 ns period
    task automatic frame(input logic [15:0] w, input int n,
                         output logic pw, output logic oe,
                         output logic [15:0] rd);
        rd = 16'h0000;
        chip_select_n = 1'h0;
        #6;
        pw = serial_out;
        oe = serial_out_oe;
        for (int i = 0; i < n; i++) begin
            serial_in = w[15-i];
            #6 link_clock = 1'h1;
            #1 rd[15-i] = serial_out;
            #5 link_clock = 1'h0;
        end
        // Bit 0 is shown at the fall of select, not after the last edge
        rd[0] = pw;
        #6 chip_select_n = 1'h1;
        // No pull on the line: show the inverse once released
        serial_in = ~serial_in;
    endtask
endmodule

// [verif/hbfp_core_tb.sv]
`timescale 1ns/10ps
module hbfp_core_tb;
    localparam int FAST = 8;
    localparam int SLOW = 16;
    logic        clock, resetn, link_clock, chip_select_n, serial_in;
    logic        serial_out, serial_out_oe, standby_pin, pw_set;
    logic        pw_reset, hot, cool, ol_dis, pw_flag, sc_flag;
    logic        shut, inhib, pw, oe;
    logic [11:0] oc, sw_on, c_lim;
    logic [15:0] rd;
    int          failures, n_compared;

    hbfp_core #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) u_dut (
        .clock(clock), .resetn(resetn), .link_clock(link_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .standby_pin(standby_pin), .temp_prewarn_set(pw_set),
        .temp_prewarn_reset(pw_reset), .temp_shutdown(hot),
        .temp_switch_on(cool), .over_current(oc), .switch_on(sw_on),
        .current_limit(c_lim), .open_load_disable(ol_dis),
        .thermal_prewarn_flag(pw_flag), .short_detect_flag(sc_flag),
        .thermal_shutdown(shut), .inhibited(inhib)
    );
    hbfp_host_model u_host (
        .link_clock(link_clock), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Ten cycles after select rises covers sync, commit and stage update
    task automatic wr(input logic [15:0] w, input int n);
        cyc(1);
        u_host.frame(w, n, pw, oe, rd);
        cyc(10);
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset();
        chk(ol_dis, 1'h1);
        chk(inhib, 1'h0);
        chk(sw_on, 12'h000);
        $display("test reset done");
    endtask

    task automatic t_write();
        wr(16'hf4b4, 16);
        chk(sw_on, 12'ha5a);
        chk(pw, 1'h0);
        chk(oe, 1'h1);
        for (int n = 1; n < 16; n += 7) begin
            wr(16'h0000, n);
            chk(sw_on, 12'ha5a);
            chk(inhib, 1'h0);
        end
        $display("test write done");
    endtask

    task automatic t_inhibit();
        standby_pin = 1'h0;
        cyc(5);
        chk(inhib, 1'h1);
        chk(sw_on, 12'h000);
        wr(16'he1fe, 16);
        chk(rd[14], 1'h1);
        standby_pin = 1'h1;
        cyc(5);
        chk(sw_on, 12'h0ff);
        wr(16'h41fe, 16);
        chk(inhib, 1'h1);
        chk(sw_on, 12'h000);
        chk(ol_dis, 1'h0);
        wr(16'he1fe, 16);
        chk(sw_on, 12'h0ff);
        chk(ol_dis, 1'h1);
        $display("test inhibit done");
    endtask

    task automatic t_prewarn();
        pw_set = 1'h1;
        cyc(4);
        chk(pw_flag, 1'h1);
        wr(16'he1fe, 16);
        chk(pw, 1'h1);
        chk(rd[0], 1'h1);
        $display("test prewarn done");
    endtask

    // Prewarning stays set throughout, it must not shorten the delay
    task automatic t_short();
        logic [15:0] w;
        int d;
        int n;
        for (int s = 0; s < 2; s++) begin
            d = s ? SLOW : FAST;
            w = 16'ha1fe | (s ? 16'h4000 : 16'h0000);
            wr(w, 16);
            oc = 12'h002;
            cyc(d - 1);
            chk(c_lim, 12'h002);
            oc = 12'h000;
            cyc(6);
            chk(sc_flag, 1'h0);
            oc = 12'h002;
            n = 0;
            while (sc_flag !== 1'h1 && n < 100) begin
                cyc(1);
                n++;
            end
            chk(n > d && n < d + 7, 1'h1);
            cyc(2);
            chk(sw_on, 12'h0fd);
            wr(w, 16);
            chk(rd & 16'h2004, 16'h2004);
            oc = 12'h000;
            wr(w | 16'h0001, 16);
            chk(sc_flag, 1'h0);
            chk(sw_on, 12'h0ff);
        end
        pw_set = 1'h0;
        pw_reset = 1'h1;
        cyc(4);
        chk(pw_flag, 1'h0);
        pw_reset = 1'h0;
        $display("test short done");
    endtask

    task automatic t_shutdown();
        hot = 1'h1;
        cyc(5);
        chk(shut, 1'h1);
        chk(sw_on, 12'h000);
        wr(16'he1fe, 16);
        chk(rd, 16'hffff);
        hot = 1'h0;
        wr(16'he1ff, 16);
        chk(shut, 1'h1);
        cool = 1'h1;
        cyc(5);
        chk(shut, 1'h1);
        wr(16'he1ff, 16);
        chk(shut, 1'h0);
        chk(sw_on, 12'h0ff);
        cool = 1'h0;
        $display("test shutdown done");
    endtask

    initial begin
        #200_000;
        failures++;
        end_sim();
    end

    initial begin
        resetn = 1'h0;
        standby_pin = 1'h1;
        pw_set = 1'h0;
        pw_reset = 1'h0;
        hot = 1'h0;
        cool = 1'h0;
        oc = 12'h000;
        failures = 0;
        n_compared = 0;
        repeat (2) @(posedge clock);
        #1 resetn = 1'h1;
        cyc(6);
        t_reset();
        t_write();
        t_inhibit();
        t_prewarn();
        t_short();
        t_shutdown();
        end_sim();
    end
endmodule
